// *** inc/ide_bm_pkg.sv ***
// Constants and carrier types shared by the bus master IDE status logic
package ide_bm_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_CH = 2;
   localparam int DATA_W = 32;
   localparam int FIFO_DEPTH = 8;
   localparam int PRI_CH = 0;
   localparam int SEC_CH = 1;

   // ----------------------------------------------------------------
   // Byte offsets from the I/O base, index 1 is the secondary channel
   // ----------------------------------------------------------------
   localparam logic [NUM_CH-1:0][3:0] CMD_OFS = {4'h8, 4'h0};
   localparam logic [NUM_CH-1:0][3:0] STAT_OFS = {4'ha, 4'h2};
   localparam logic [NUM_CH-1:0][3:0] BASE_OFS = {4'hc, 4'h4};

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CMD_SS_BIT = 0;
   localparam int CMD_DIR_BIT = 3;
   localparam int STAT_RSVD_BIT = 7;
   localparam int STAT_CAP1_BIT = 6;
   localparam int STAT_CAP0_BIT = 5;
   localparam int STAT_IRQ_BIT = 2;
   localparam int STAT_ERR_BIT = 1;
   localparam int STAT_ACT_BIT = 0;
   localparam int BASE_LSB = 2;
   localparam int BYTE_W = 8;
   localparam int LANES = 4;
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [29:0] BASE_RST = 30'h0000_0000;
   localparam logic [1:0] BASE_LOW_RD = 2'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_DRAIN} chan_state_t;

   typedef struct packed {
      logic sel;
      logic wr;
      logic [3:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } io_req_t;

   typedef struct packed {
      logic eot_done;
      logic pci_abort;
   } eng_evt_t;

   typedef struct packed {
      logic start_stop_bit;
      logic transfer_direction;
      logic transfer_active;
      logic [29:0] desc_base;
   } chan_ctl_t;

   typedef struct packed {
      logic isa_irq_fourteen;
      logic isa_irq_fifteen;
      logic steerable_irq_line_a;
      logic steer_a_to_fifteen;
   } irq_in_t;

   typedef struct packed {
      chan_state_t state;
      logic start_stop_bit;
      logic transfer_direction;
      logic drive1_dma_capable;
      logic drive0_dma_capable;
      logic irq;
      logic err;
      logic [29:0] base;
   } chan_st_t;

   localparam chan_st_t CH_RST = '{state: CH_IDLE,
      start_stop_bit: CMD_RST[CMD_SS_BIT],
      transfer_direction: CMD_RST[CMD_DIR_BIT],
      drive1_dma_capable: STAT_RST[STAT_CAP1_BIT],
      drive0_dma_capable: STAT_RST[STAT_CAP0_BIT],
      irq: STAT_RST[STAT_IRQ_BIT], err: STAT_RST[STAT_ERR_BIT],
      base: BASE_RST};

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Write strobe for one byte at a byte offset
   function automatic logic lane_hit(input io_req_t r,
                                     input logic [3:0] ofs);
      return r.sel && r.wr && r.be[ofs[1:0]] &&
             (r.addr[3:2] == ofs[3:2]);
   endfunction : lane_hit

   // Write data byte that belongs to a byte offset
   function automatic logic [7:0] lane_byte(input io_req_t r,
                                            input logic [3:0] ofs);
      return r.wdata[{ofs[1:0], 3'b000} +: BYTE_W];
   endfunction : lane_byte

endpackage : ide_bm_pkg

// *** hw/bm_sync_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a flush
`timescale 1ns/10ps
module bm_sync_fifo
   import ide_bm_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic empty
);
   // Pointers wrap naturally, so DEPTH must be a power of two
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] CNT_FULL = (PTR_W + 1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] wr_ptr;
      logic [PTR_W-1:0] rd_ptr;
      logic [PTR_W:0] count;
   } fifo_st_t;

   fifo_st_t state_ff, nxt_state;
   logic push, pop;

   // ----------------------------------------------------------------
   // Handshakes
   // ----------------------------------------------------------------
   assign in_ready = (state_ff.count != CNT_FULL);
   assign out_valid = (state_ff.count != '0);
   assign empty = (state_ff.count == '0);
   assign out_data = state_ff.mem[state_ff.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Next state; flush beats a push in the same cycle
   always_comb
   begin
      nxt_state = state_ff;
      if (push)
      begin
         nxt_state.mem[state_ff.wr_ptr] = in_data;
         nxt_state.wr_ptr = state_ff.wr_ptr + 1'b1;
      end
      if (pop)
         nxt_state.rd_ptr = state_ff.rd_ptr + 1'b1;
      nxt_state.count = state_ff.count + {{PTR_W{1'b0}}, push} -
                        {{PTR_W{1'b0}}, pop};
      if (flush)
      begin
         nxt_state.wr_ptr = '0;
         nxt_state.rd_ptr = '0;
         nxt_state.count = '0;
      end
   end

   // State register
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

endmodule : bm_sync_fifo

// *** hw/bm_irq_edge.sv ***
// Drive interrupt source selection and assertion edge detection
`timescale 1ns/10ps
module bm_irq_edge
   import ide_bm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire irq_in_t irq_in,
   output logic [NUM_CH-1:0] irq_edge
);
   typedef struct packed {
      logic [NUM_CH-1:0] prev;
   } edge_st_t;

   edge_st_t state_ff, nxt_state;
   logic [NUM_CH-1:0] line;

   // ----------------------------------------------------------------
   // Source mux; flipping the steering bit may look like an edge
   // ----------------------------------------------------------------
   always_comb
   begin
      line[PRI_CH] = irq_in.isa_irq_fourteen;
      line[SEC_CH] = irq_in.steer_a_to_fifteen ?
                     irq_in.isa_irq_fifteen :
                     irq_in.steerable_irq_line_a;
      nxt_state.prev = line;
   end

   // Only a rising edge arms the status bit, never the level
   assign irq_edge = line & ~state_ff.prev;

   // State register
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

endmodule : bm_irq_edge

// *** hw/ide_bm_status.sv ***
// Two-channel bus master IDE status, command and descriptor pointer logic
// Function
// - Separate status and pointer registers per channel at distinct offsets.
// - Status bit 7 always reads zero.
// - Drive DMA capable bits are plain software flags without effect.
// - Interrupt status sets when the channel's drive interrupt asserts.
// - Interrupt and error bits clear on writing one; zero leaves them.
// - Cleared while line still high, bit stays zero until new edge.
// - Primary uses ISA line 14; secondary steerable line, or 15 if routed.
// - Error bit sets on PCI target or master abort.
// - Active bit sets when software sets the start/stop bit.
// - Active clears after the final transfer of the end-of-table region.
// - Active also clears on stop write or when error sets.
// - Active zero means all drive data reached memory unless aborted.
// - Running without drive interrupt shows interrupt 0, active 1.
// - Normal completion shows interrupt 1, active 0, data delivered.
// - Interrupt with active still 1 is a valid early completion.
// - Both zero flags an error: memory fault or short descriptors.
// - Pointer holds table base bits 31 to 2; low bits reserved.
// - Stop discards all transfer state; no resume.
`timescale 1ns/10ps
module ide_bm_status
   import ide_bm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire io_req_t io_req,
   output logic [31:0] io_rdata,
   input wire eng_evt_t [NUM_CH-1:0] eng_evt,
   input wire irq_in_t irq_in,
   output chan_ctl_t [NUM_CH-1:0] chan_ctl,
   input wire logic [NUM_CH-1:0] drv_valid,
   input wire logic [NUM_CH-1:0][DATA_W-1:0] drv_data,
   output logic [NUM_CH-1:0] drv_ready,
   output logic [NUM_CH-1:0] mem_valid,
   output logic [NUM_CH-1:0][DATA_W-1:0] mem_data,
   input wire logic [NUM_CH-1:0] mem_ready
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      chan_st_t [NUM_CH-1:0] ch;
      logic [31:0] rdata;
   } top_st_t;

   localparam top_st_t TOP_RST = '{ch: {NUM_CH{CH_RST}},
                                   rdata: 32'h0000_0000};

   top_st_t state_ff, nxt_state;

   logic [NUM_CH-1:0] irq_edge;
   logic [NUM_CH-1:0] fifo_empty;
   logic [NUM_CH-1:0] fifo_in_ready;
   logic [NUM_CH-1:0] fifo_in_valid;
   logic [NUM_CH-1:0] fifo_flush;
   logic [NUM_CH-1:0] running;
   logic [NUM_CH-1:0] cmd_hit;
   logic [NUM_CH-1:0] stat_hit;
   logic [NUM_CH-1:0][7:0] cmd_b;
   logic [NUM_CH-1:0][7:0] stat_b;

   default clocking cb_sys @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   // ----------------------------------------------------------------
   // Read-back helpers
   // ----------------------------------------------------------------
   // Status byte; bit 7 and bits 4:3 are left at zero
   function automatic logic [7:0] stat_byte(input chan_st_t s);
      logic [7:0] b;
      b = STAT_RST;
      b[STAT_CAP1_BIT] = s.drive1_dma_capable;
      b[STAT_CAP0_BIT] = s.drive0_dma_capable;
      b[STAT_IRQ_BIT] = s.irq;
      b[STAT_ERR_BIT] = s.err;
      // Irq/active pairs 01, 10, 11, 00 tell the outcome
      b[STAT_ACT_BIT] = (s.state != CH_IDLE);
      return b;
   endfunction : stat_byte

   // Command byte; reserved bits read zero
   function automatic logic [7:0] cmd_byte(input chan_st_t s);
      logic [7:0] b;
      b = CMD_RST;
      b[CMD_SS_BIT] = s.start_stop_bit;
      b[CMD_DIR_BIT] = s.transfer_direction;
      return b;
   endfunction : cmd_byte

   // ----------------------------------------------------------------
   // Interrupt source and edge detection
   // ----------------------------------------------------------------
   bm_irq_edge u_irq_edge (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .irq_in(irq_in),
      .irq_edge(irq_edge)
   );

   // ----------------------------------------------------------------
   // Per channel decode, data buffer and checks
   // ----------------------------------------------------------------
   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_chan
      localparam int SL = BYTE_W * int'(STAT_OFS[c][1:0]);

      // Byte strobes for the channel's own registers
      assign cmd_hit[c] = lane_hit(io_req, CMD_OFS[c]);
      assign stat_hit[c] = lane_hit(io_req, STAT_OFS[c]);
      assign cmd_b[c] = lane_byte(io_req, CMD_OFS[c]);
      assign stat_b[c] = lane_byte(io_req, STAT_OFS[c]);

      // Stop or abort throws buffered data away, no resume later
      assign fifo_flush[c] = (cmd_hit[c] && !cmd_b[c][CMD_SS_BIT]) ||
                             eng_evt[c].pci_abort;
      assign running[c] = (state_ff.ch[c].state == CH_RUN);

      // Drive data only moves while the channel is in CH_RUN, not in CH_DRAIN
      assign fifo_in_valid[c] = drv_valid[c] && running[c];
      assign drv_ready[c] = fifo_in_ready[c] && running[c];

      bm_sync_fifo #(
         .WIDTH(DATA_W),
         .DEPTH(FIFO_DEPTH)
      ) u_fifo (
         .sys_clk(sys_clk),
         .nrst(nrst),
         .flush(fifo_flush[c]),
         .in_valid(fifo_in_valid[c]),
         .in_ready(fifo_in_ready[c]),
         .in_data(drv_data[c]),
         .out_valid(mem_valid[c]),
         .out_ready(mem_ready[c]),
         .out_data(mem_data[c]),
         .empty(fifo_empty[c])
      );

      // Control outputs straight from the registers
      assign chan_ctl[c].start_stop_bit = state_ff.ch[c].start_stop_bit;
      assign chan_ctl[c].transfer_direction =
         state_ff.ch[c].transfer_direction;
      assign chan_ctl[c].transfer_active =
         (state_ff.ch[c].state != CH_IDLE);
      assign chan_ctl[c].desc_base = state_ff.ch[c].base;

      // Start write that no stop or abort overrides
      sequence s_start;
         cmd_hit[c] && cmd_b[c][CMD_SS_BIT] &&
         !state_ff.ch[c].start_stop_bit && !fifo_flush[c];
      endsequence

      // End of table seen, buffer still holding drive data
      sequence s_eot_busy;
         (running[c] && eng_evt[c].eot_done && !fifo_flush[c]) ##1
         (!fifo_empty[c] && !fifo_flush[c]);
      endsequence

      a_bit7_zero: assert property (
         (io_req.sel && !io_req.wr &&
          io_req.addr[3:2] == STAT_OFS[c][3:2])
         |=> !io_rdata[SL + STAT_RSVD_BIT])
         else $error("status bit 7 read as one");

      a_cap_stable: assert property (
         !stat_hit[c] |=> $stable(state_ff.ch[c].drive1_dma_capable) &&
                          $stable(state_ff.ch[c].drive0_dma_capable))
         else $error("capable flag changed without a write");

      a_irq_set_edge: assert property (
         irq_edge[c] |=> state_ff.ch[c].irq)
         else $error("interrupt edge did not set status");

      a_w1c_clears: assert property (
         (stat_hit[c] && stat_b[c][STAT_IRQ_BIT] && !irq_edge[c])
         |=> !state_ff.ch[c].irq)
         else $error("write one did not clear interrupt status");

      a_zero_keeps_err: assert property (
         (state_ff.ch[c].err && !(stat_hit[c] && stat_b[c][STAT_ERR_BIT]))
         |=> state_ff.ch[c].err)
         else $error("error bit lost without a write of one");

      a_irq_no_rearm: assert property (
         (!state_ff.ch[c].irq && !irq_edge[c]) |=> !state_ff.ch[c].irq)
         else $error("interrupt status set without an edge");

      a_abort_err: assert property (
         eng_evt[c].pci_abort
         |=> state_ff.ch[c].err && (state_ff.ch[c].state == CH_IDLE))
         else $error("abort did not set error and stop");

      a_start_active: assert property (
         s_start |=> chan_ctl[c].transfer_active ##0 running[c])
         else $error("start did not make the channel active");

      a_eot_drain: assert property (
         s_eot_busy |-> chan_ctl[c].transfer_active)
         else $error("active dropped with data still buffered");

      a_drain_done: assert property (
         (state_ff.ch[c].state == CH_DRAIN && fifo_empty[c] &&
          !fifo_flush[c]) |=> !chan_ctl[c].transfer_active)
         else $error("active did not clear after last transfer");

      a_stop_idle: assert property (
         (cmd_hit[c] && !cmd_b[c][CMD_SS_BIT])
         |=> !chan_ctl[c].transfer_active && fifo_empty[c])
         else $error("stop left the channel active or buffered");

      a_base_low: assert property (
         (io_req.sel && !io_req.wr &&
          io_req.addr[3:2] == BASE_OFS[c][3:2])
         |=> io_rdata[BASE_LSB-1:0] == BASE_LOW_RD)
         else $error("pointer low bits read nonzero");

      a_base_store: assert property (
         (io_req.sel && io_req.wr && io_req.be == {LANES{1'b1}} &&
          io_req.addr[3:2] == BASE_OFS[c][3:2])
         |=> state_ff.ch[c].base == $past(io_req.wdata[31:BASE_LSB]))
         else $error("pointer did not store written address");
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [31:0] w;
      logic [31:0] rd;
      w = 32'h0000_0000;
      rd = 32'h0000_0000;
      nxt_state = state_ff;
      for (int c = 0; c < NUM_CH; c++)
      begin
         // Command byte; direction is stored even while active
         if (cmd_hit[c])
         begin
            nxt_state.ch[c].start_stop_bit = cmd_b[c][CMD_SS_BIT];
            nxt_state.ch[c].transfer_direction =
               cmd_b[c][CMD_DIR_BIT];
         end

         // Software flags, stored and never looked at again
         if (stat_hit[c])
         begin
            nxt_state.ch[c].drive1_dma_capable =
               stat_b[c][STAT_CAP1_BIT];
            nxt_state.ch[c].drive0_dma_capable =
               stat_b[c][STAT_CAP0_BIT];
         end

         // Write one clears; an event in the same cycle wins
         if (stat_hit[c] && stat_b[c][STAT_IRQ_BIT])
            nxt_state.ch[c].irq = 1'b0;
         if (irq_edge[c])
            nxt_state.ch[c].irq = 1'b1;
         if (stat_hit[c] && stat_b[c][STAT_ERR_BIT])
            nxt_state.ch[c].err = 1'b0;
         if (eng_evt[c].pci_abort)
            nxt_state.ch[c].err = 1'b1;

         // Pointer by byte lanes; the two low bits are not kept
         w = {state_ff.ch[c].base, BASE_LOW_RD};
         for (int b = 0; b < LANES; b++)
         begin
            if (lane_hit(io_req, BASE_OFS[c] | 4'(b)))
               w[b*BYTE_W +: BYTE_W] = io_req.wdata[b*BYTE_W +: BYTE_W];
         end
         nxt_state.ch[c].base = w[31:BASE_LSB];

         // Transfer sequencing
         unique case (state_ff.ch[c].state)
            CH_IDLE:
               if (cmd_hit[c] && cmd_b[c][CMD_SS_BIT] &&
                   !state_ff.ch[c].start_stop_bit)
                  nxt_state.ch[c].state = CH_RUN;
            CH_RUN:
               if (eng_evt[c].eot_done)
                  nxt_state.ch[c].state = CH_DRAIN;
            CH_DRAIN:
               // Hold active until buffered drive data is in memory
               if (fifo_empty[c])
                  nxt_state.ch[c].state = CH_IDLE;
            default:
               nxt_state.ch[c].state = CH_IDLE;
         endcase
         if (fifo_flush[c])
            nxt_state.ch[c].state = CH_IDLE;
      end

      // Read data, registered; reads have no side effects
      if (io_req.sel && !io_req.wr)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (io_req.addr[3:2] == CMD_OFS[c][3:2])
            begin
               rd[{CMD_OFS[c][1:0], 3'b000} +: BYTE_W] =
                  cmd_byte(state_ff.ch[c]);
               rd[{STAT_OFS[c][1:0], 3'b000} +: BYTE_W] =
                  stat_byte(state_ff.ch[c]);
            end
            if (io_req.addr[3:2] == BASE_OFS[c][3:2])
               rd = {state_ff.ch[c].base, BASE_LOW_RD};
         end
         nxt_state.rdata = rd;
      end
   end

   assign io_rdata = state_ff.rdata;

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         state_ff <= TOP_RST;
      else
         state_ff <= nxt_state;
   end

endmodule : ide_bm_status

// *** testbench/ide_far_model.sv ***
// Far side model: drive data source and system memory sink
`timescale 1ns/10ps
module ide_far_model
   import ide_bm_pkg::*;
(
   input wire logic sys_clk,
   input wire logic en,
   input wire logic stall,
   input wire logic [NUM_CH-1:0] drv_ready,
   output logic [NUM_CH-1:0] drv_valid,
   output logic [NUM_CH-1:0][DATA_W-1:0] drv_data,
   output logic [NUM_CH-1:0] mem_ready
);
   int seed = 94;
   logic [NUM_CH-1:0] took = '0;
   logic [NUM_CH-1:0][DATA_W-1:0] cnt = '0;
   initial
   begin
      drv_valid = '0;
      drv_data = '0;
      mem_ready = '0;
   end
   // ------------------------------------------------------------
   // Handshake seen on the rising edge, new offer on the falling
   // ------------------------------------------------------------
   always @(posedge sys_clk)
      took <= drv_valid & drv_ready;
   // A word stays offered until taken; released data is inverted
   always @(negedge sys_clk)
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         if (took[c])
            cnt[c] = cnt[c] + 32'h1;
         if (!drv_valid[c] || took[c])
         begin
            drv_valid[c] = en && ($random(seed) % 4 != 0);
            drv_data[c] = drv_valid[c] ? cnt[c] : ~drv_data[c];
         end
         mem_ready[c] = !stall && ($random(seed) % 3 != 0);
      end
   end
endmodule : ide_far_model

// *** testbench/ide_bm_status_test.sv ***
// Self-checking bench for the bus master IDE status logic
`timescale 1ns/10ps
module ide_bm_status_test
   import ide_bm_pkg::*;
   ;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   io_req_t io_req = '0;
   logic [31:0] io_rdata;
   eng_evt_t [NUM_CH-1:0] eng_evt = '0;
   irq_in_t irq_in = '0;
   chan_ctl_t [NUM_CH-1:0] chan_ctl;
   logic [NUM_CH-1:0] drv_valid, drv_ready, mem_valid, mem_ready;
   logic [NUM_CH-1:0][DATA_W-1:0] drv_data, mem_data;
   logic en = 1'b0, stall = 1'b0, rd_q = 1'b0;
   int failures = 0, total_checks = 0, seed = 94;
   logic [31:0] rq[$], dq[$], p;
   ide_bm_status i_dut (.sys_clk(sys_clk), .nrst(nrst), .io_req(io_req),
      .io_rdata(io_rdata), .eng_evt(eng_evt), .irq_in(irq_in),
      .chan_ctl(chan_ctl), .drv_valid(drv_valid), .drv_data(drv_data),
      .drv_ready(drv_ready), .mem_valid(mem_valid), .mem_data(mem_data),
      .mem_ready(mem_ready));
   ide_far_model i_far (.sys_clk(sys_clk), .en(en), .stall(stall),
      .drv_ready(drv_ready), .drv_valid(drv_valid), .drv_data(drv_data),
      .mem_ready(mem_ready));
   // ------------------------------------------------------------
   // Clock and shared tasks
   // ------------------------------------------------------------
   initial
      forever #25 sys_clk = ~sys_clk;
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // One access per call; sel drops for a cycle between calls
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [3:0] b, input logic [31:0] d);
      @(negedge sys_clk);
      io_req <= '{1'b1, w, a, b, d};
      @(negedge sys_clk);
      io_req <= '0;
   endtask : acc
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      rq.push_back(e);
      acc(1'b0, a, 4'hf, 32'h0);
   endtask : rd
   task automatic wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : wt
   task automatic pulse(input bit abort);
      @(negedge sys_clk);
      eng_evt[0] <= abort ? 2'b01 : 2'b10;
      @(negedge sys_clk);
      eng_evt[0] <= '0;
   endtask : pulse
   // Bounded wait for the active flag to drop
   task automatic wait_idle;
      int k;
      for (k = 0; k < 200 && chan_ctl[0].transfer_active !== 1'b0; k++)
         @(negedge sys_clk);
      if (k == 200)
      begin
         failures++;
         complete_run;
      end
   endtask : wait_idle
   // ------------------------------------------------------------
   // Watchers: read data half a cycle after the take, memory words
   // ------------------------------------------------------------
   always @(posedge sys_clk)
      rd_q <= io_req.sel & ~io_req.wr;
   always @(negedge sys_clk)
      if (rd_q)
         chk("io_rdata", io_rdata, rq.pop_front());
   always @(posedge sys_clk)
   begin
      if (mem_valid[0] && mem_ready[0])
         chk("mem_data", mem_data[0], dq.pop_front());
      if (drv_valid[0] && drv_ready[0])
         dq.push_back(drv_data[0]);
   end
   initial
   begin
      #4000000;
      failures++;
      complete_run;
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      wt(8);
      nrst = 1'b1;
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h0);
      rd(4'hc, 32'h0);
      $display("reset values done");
      acc(1'b1, 4'h0, 4'h4, 32'h00ff_0000);
      acc(1'b1, 4'h8, 4'h4, 32'h00c0_0000);
      rd(4'h0, 32'h0060_0000);
      rd(4'h8, 32'h0040_0000);
      acc(1'b1, 4'h4, 4'hf, 32'hffff_ffff);
      rd(4'h4, 32'hffff_fffc);
      chk("base0", {2'b0, chan_ctl[0].desc_base}, 32'h3fff_ffff);
      p = $random(seed) & 32'hffff_fffc;
      acc(1'b1, 4'hc, 4'hf, p);
      acc(1'b1, 4'hc, 4'h1, 32'h0);
      rd(4'hc, {p[31:8], 8'h00});
      chk("base1", {chan_ctl[1].desc_base, 2'b0}, {p[31:8], 8'h0});
      $display("register access done");
      acc(1'b1, 4'h0, 4'h1, 32'h9);
      chk("active", chan_ctl[0].transfer_active, 1'b1);
      chk("start", chan_ctl[0].start_stop_bit, 1'b1);
      chk("dir", chan_ctl[0].transfer_direction, 1'b1);
      rd(4'h0, 32'h0061_0009);
      en <= 1'b1;
      stall <= 1'b1;
      wt(30);
      chk("drv_ready", drv_ready[0], 1'b0);
      stall <= 1'b0;
      irq_in.isa_irq_fourteen <= 1'b1;
      wt(3);
      rd(4'h0, 32'h0065_0009);
      acc(1'b1, 4'h0, 4'h4, 32'h0064_0000);
      wt(3);
      rd(4'h0, 32'h0061_0009);
      irq_in.isa_irq_fourteen <= 1'b0;
      wt(2);
      irq_in.isa_irq_fourteen <= 1'b1;
      wt(2);
      pulse(1'b0);
      wait_idle();
      chk("drained", dq.size(), 32'h0);
      en <= 1'b0;
      acc(1'b1, 4'h0, 4'h1, 32'h0);
      rd(4'h0, 32'h0064_0000);
      irq_in.isa_irq_fourteen <= 1'b0;
      acc(1'b1, 4'h0, 4'h4, 32'h0064_0000);
      $display("transfer and interrupt done");
      acc(1'b1, 4'h0, 4'h1, 32'h1);
      pulse(1'b1);
      rd(4'h0, 32'h0062_0001);
      acc(1'b1, 4'h0, 4'h4, 32'h0060_0000);
      rd(4'h0, 32'h0062_0001);
      acc(1'b1, 4'h0, 4'h4, 32'h0062_0000);
      rd(4'h0, 32'h0060_0001);
      acc(1'b1, 4'h0, 4'h1, 32'h0);
      acc(1'b1, 4'h0, 4'h1, 32'h1);
      rd(4'h0, 32'h0061_0001);
      acc(1'b1, 4'h0, 4'h1, 32'h0);
      rd(4'h0, 32'h0060_0000);
      $display("abort and stop done");
      for (int s = 0; s < 2; s++)
      begin
         irq_in <= '{1'b0, 1'b0, 1'b0, s[0]};
         wt(3);
         if (s == 0)
            irq_in.isa_irq_fifteen <= 1'b1;
         else
            irq_in.steerable_irq_line_a <= 1'b1;
         wt(3);
         rd(4'h8, 32'h0040_0000);
         irq_in <= '1;
         wt(3);
         rd(4'h8, 32'h0044_0000);
         irq_in <= '{1'b0, 1'b0, 1'b0, s[0]};
         acc(1'b1, 4'h8, 4'h4, 32'h0044_0000);
         rd(4'h8, 32'h0040_0000);
      end
      $display("interrupt routing done");
      acc(1'b1, 4'h8, 4'h1, 32'h1);
      chk("active1", chan_ctl[1].transfer_active, 1'b1);
      rd(4'h8, 32'h0041_0001);
      acc(1'b1, 4'h8, 4'h1, 32'h0);
      rd(4'h8, 32'h0040_0000);
      $display("secondary start and stop done");
      wt(4);
      complete_run();
   end
endmodule : ide_bm_status_test
